// ==== src/adc_readout_pkg.sv ====
// Constants shared by the dual converter readout logic.
// Assumes a 40 MHz system clock and a plain register port.
package adc_readout_pkg;

    localparam int unsigned SYS_CLK_PERIOD_PS = 25000;
    // Least strobe high time seen by the far end
    localparam int unsigned STROBE_MIN_NS     = 25;
    localparam int unsigned STROBE_MIN_CYC    =
        (STROBE_MIN_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
    // Settling after supply return or sleep exit
    localparam int unsigned SETTLE_MS         = 10;
    localparam int unsigned SETTLE_CYC        =
        (SETTLE_MS * 1000000 + SYS_CLK_PERIOD_PS / 1000 - 1)
        / (SYS_CLK_PERIOD_PS / 1000);

    localparam int unsigned RESULT_W = 16;
    localparam int unsigned LANES    = 2;

    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] PATTERN_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS  = 4'h8;
    localparam int unsigned CTRL_PAT_BIT = 0;
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] PATTERN_RST = 16'h0000;

    typedef enum logic [1:0] {
        PWR_OPER,
        PWR_NAP,
        PWR_SLEEP
    } pwr_state_t;

endpackage

// ==== src/pin_sync.sv ====
// Two flip-flop synchroniser for a group of pin levels.
// Assumes levels that change slowly against the local clock.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ==== src/lane_shifter.sv ====
// Parallel-load shift registers, one per serial data lane.
// Assumes load and shift never coincide with reset.
`timescale 1ns/1ps
module lane_shifter #(
    parameter int W     = 16,
    parameter int LANES = 2
) (
    input  wire logic               i_sys_clk,
    input  wire logic               i_srst,
    input  wire logic               i_load,
    input  wire logic               i_shift,
    input  wire logic [LANES*W-1:0] i_words,
    output logic      [LANES-1:0]   o_bits
);
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [W-1:0] word_r;
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    word_r    <= '0;
                    o_bits[g] <= 1'b0;
                end else if (i_load) begin
                    word_r    <= i_words[g*W +: W];
                    o_bits[g] <= 1'b0;
                end else if (i_shift) begin
                    // MSB leaves first
                    o_bits[g] <= word_r[W-1];
                    word_r    <= {word_r[W-2:0], 1'b0};
                end
            end
        end
    endgenerate
endmodule

// ==== src/dual_sar_adc_serial_readout.sv ====
// Conversion control, two-lane serial readout and nap/sleep sequencing.
// Assumes strobe, serial clock and straps come from pins; results from
// the converter core arrive on the system clock.
`timescale 1ns/1ps
// Operation
// - Strobe rise starts tracking in operating state only
// - Strobe fall holds and converts both
// - Falling serial clock shifts bits, MSB first
// - Echo clock skew matches data lanes
// - CMOS: echo clock off when strap high
// - Second strobe rise enters nap
// - Serial clock rise leaves nap
// - Two more strobes go nap to sleep
// - CMOS: serial clock rise leaves sleep
// - Fifth strobe leaves sleep
// - Strobes alone cycle states forever
// - Low supply resets and reinitialises
// - Strap selects CMOS or LVDS
// - CMOS: negative pins held low
// - LVDS: differential lanes and clock
// - Shifted bits from same conversion
module dual_sar_adc_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = adc_readout_pkg::SETTLE_CYC
) (
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_srst,
    input  wire logic                            i_conversion_strobe,
    input  wire logic                            i_sck_p,
    input  wire logic                            i_sck_n,
    input  wire logic                            i_lvds_sel,
    input  wire logic                            i_echo_clock_out_n,
    input  wire logic                            i_supply_ok,
    input  wire logic [adc_readout_pkg::RESULT_W-1:0] i_ch1_result,
    input  wire logic [adc_readout_pkg::RESULT_W-1:0] i_ch2_result,
    input  wire logic [3:0]                      i_addr,
    input  wire logic [15:0]                     i_wdata,
    input  wire logic                            i_wr,
    input  wire logic                            i_rd,
    output logic      [15:0]                     o_rdata,
    output logic                                 o_track,
    output logic                                 o_conv_start,
    output logic                                 o_serial_out_ch1_p,
    output logic                                 o_serial_out_ch1_n,
    output logic                                 o_serial_out_ch2_p,
    output logic                                 o_serial_out_ch2_n,
    output logic                                 o_echo_clock_out_p,
    output logic                                 o_echo_clock_out_n,
    output logic                                 o_echo_clock_out_n_oe,
    output logic [1:0]                           o_power_state,
    output logic                                 o_settling
);
    import adc_readout_pkg::*;

    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CYCLES);

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    // Pin synchronisation
    logic [5:0] pins_s;
    pin_sync #(.W(6)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_async   ({i_supply_ok, i_echo_clock_out_n, i_lvds_sel,
                     i_sck_n, i_sck_p, i_conversion_strobe}),
        .o_sync    (pins_s)
    );

    logic       strobe_s;
    logic       lvds_s;
    logic       echo_strap_s;
    logic       supply_s;
    logic       sck_s;
    assign strobe_s     = pins_s[0];
    assign lvds_s       = pins_s[3];
    assign echo_strap_s = pins_s[4];
    assign supply_s     = pins_s[5];
    // Differential receiver in LVDS, single pin in CMOS
    assign sck_s = lvds_s ? (pins_s[1] & ~pins_s[2]) : pins_s[1];

    logic strobe_d_r;
    logic sck_d_r;
    logic strobe_rise;
    logic strobe_fall;
    logic sck_rise;
    logic sck_fall;
    logic int_rst;

    assign int_rst = i_srst | ~supply_s;

    always_ff @(posedge i_sys_clk) begin
        if (int_rst) begin
            strobe_d_r <= 1'b0;
            sck_d_r    <= 1'b0;
        end else begin
            strobe_d_r <= strobe_s;
            sck_d_r    <= sck_s;
        end
    end

    assign strobe_rise = strobe_s & ~strobe_d_r;
    assign strobe_fall = ~strobe_s & strobe_d_r;
    assign sck_rise    = sck_s & ~sck_d_r;
    assign sck_fall    = ~sck_s & sck_d_r;

    // Registers
    logic [15:0] ctrl_r;
    logic [15:0] pattern_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_r    <= CTRL_RST;
            pattern_r <= PATTERN_RST;
        end else if (i_wr) begin
            if (hit(i_addr, CTRL_OFS))
                ctrl_r <= i_wdata;
            if (hit(i_addr, PATTERN_OFS))
                pattern_r <= i_wdata;
        end
    end

    // Power state sequencing
    pwr_state_t state_r;
    logic [2:0] pcnt_r;

    always_ff @(posedge i_sys_clk) begin
        if (int_rst) begin
            state_r <= PWR_OPER;
            pcnt_r  <= 3'h0;
        end else if (sck_rise) begin
            case (state_r)
                PWR_OPER: pcnt_r <= 3'h0;
                PWR_NAP: begin
                    state_r <= PWR_OPER;
                    pcnt_r  <= 3'h0;
                end
                PWR_SLEEP: begin
                    if (!lvds_s) begin
                        state_r <= PWR_OPER;
                        pcnt_r  <= 3'h0;
                    end
                end
                default: state_r <= PWR_OPER;
            endcase
        end else if (strobe_rise) begin
            case (state_r)
                PWR_OPER: begin
                    if (pcnt_r == 3'h1)
                        state_r <= PWR_NAP;
                    pcnt_r <= pcnt_r + 3'h1;
                end
                PWR_NAP: begin
                    if (pcnt_r == 3'h3)
                        state_r <= PWR_SLEEP;
                    pcnt_r <= pcnt_r + 3'h1;
                end
                PWR_SLEEP: begin
                    state_r <= PWR_OPER;
                    pcnt_r  <= 3'h0;
                end
                default: state_r <= PWR_OPER;
            endcase
        end
    end

    // Settling timer after supply return or sleep exit
    logic [CW-1:0] settle_r;
    always_ff @(posedge i_sys_clk) begin
        if (int_rst)
            settle_r <= SETTLE_LOAD;
        else if (state_r == PWR_SLEEP)
            settle_r <= SETTLE_LOAD;
        else if (settle_r != '0)
            settle_r <= settle_r - CW'(1);
    end

    // Sample-and-hold and conversion start
    logic conv_go;
    assign conv_go = strobe_fall & o_track;

    always_ff @(posedge i_sys_clk) begin
        if (int_rst) begin
            o_track      <= 1'b0;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= conv_go;
            if (strobe_rise && state_r == PWR_OPER && !sck_rise)
                o_track <= 1'b1;
            else if (strobe_fall)
                o_track <= 1'b0;
        end
    end

    // Result lanes loaded at conversion start, no pipeline
    logic [RESULT_W-1:0] ch1_word;
    logic [RESULT_W-1:0] ch2_word;
    logic [1:0]          lane_bits;
    assign ch1_word = ctrl_r[CTRL_PAT_BIT] ? pattern_r : i_ch1_result;
    assign ch2_word = ctrl_r[CTRL_PAT_BIT] ? ~pattern_r : i_ch2_result;

    lane_shifter #(.W(RESULT_W), .LANES(LANES)) u_shift (
        .i_sys_clk (i_sys_clk),
        .i_srst    (int_rst),
        .i_load    (conv_go),
        .i_shift   (sck_fall),
        .i_words   ({ch2_word, ch1_word}),
        .o_bits    (lane_bits)
    );

    // Pin drivers; echo follows the same flop depth as data
    logic echo_en;
    assign echo_en = lvds_s | ~echo_strap_s;

    always_ff @(posedge i_sys_clk) begin
        if (int_rst) begin
            o_serial_out_ch1_p    <= 1'b0;
            o_serial_out_ch1_n    <= 1'b0;
            o_serial_out_ch2_p    <= 1'b0;
            o_serial_out_ch2_n    <= 1'b0;
            o_echo_clock_out_p    <= 1'b0;
            o_echo_clock_out_n    <= 1'b0;
            o_echo_clock_out_n_oe <= 1'b0;
        end else begin
            o_serial_out_ch1_p    <= lane_bits[0];
            o_serial_out_ch2_p    <= lane_bits[1];
            o_serial_out_ch1_n    <= lvds_s & ~lane_bits[0];
            o_serial_out_ch2_n    <= lvds_s & ~lane_bits[1];
            o_echo_clock_out_p    <= echo_en & sck_d_r;
            o_echo_clock_out_n    <= lvds_s & ~sck_d_r;
            o_echo_clock_out_n_oe <= lvds_s;
        end
    end

    // Status and read port
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_power_state <= 2'h0;
            o_settling    <= 1'b1;
            o_rdata       <= 16'h0000;
        end else begin
            o_power_state <= state_r;
            o_settling    <= int_rst || settle_r != '0;
            if (!i_rd)
                o_rdata <= 16'h0000;
            else if (hit(i_addr, CTRL_OFS))
                o_rdata <= ctrl_r;
            else if (hit(i_addr, PATTERN_OFS))
                o_rdata <= pattern_r;
            else if (hit(i_addr, STATUS_OFS))
                o_rdata <= {10'h000, settle_r != '0, echo_en, lvds_s,
                            pcnt_r == 3'h0, state_r};
            else
                o_rdata <= 16'h0000;
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    property p_track;
        strobe_rise && state_r == PWR_OPER && !sck_rise && supply_s
            |=> o_track;
    endproperty
    a_track: assert property (p_track)
        else $error("tracking did not start");

    property p_hold;
        strobe_fall && o_track && supply_s |=> !o_track && o_conv_start;
    endproperty
    a_hold: assert property (p_hold)
        else $error("conversion did not start");

    property p_nap;
        state_r == PWR_OPER && pcnt_r == 3'h1 && strobe_rise && !sck_rise
            && supply_s |=> state_r == PWR_NAP;
    endproperty
    a_nap: assert property (p_nap)
        else $error("nap not entered");

    property p_nap_wake;
        state_r == PWR_NAP && sck_rise && supply_s |=> state_r == PWR_OPER;
    endproperty
    a_nap_wake: assert property (p_nap_wake)
        else $error("nap not left");

    property p_sleep;
        state_r == PWR_NAP && pcnt_r == 3'h3 && strobe_rise && !sck_rise
            && supply_s |=> state_r == PWR_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep not entered");

    property p_sleep_sck;
        state_r == PWR_SLEEP && sck_rise && supply_s
            |=> (state_r == PWR_OPER) == !$past(lvds_s);
    endproperty
    a_sleep_sck: assert property (p_sleep_sck)
        else $error("sleep exit by serial clock wrong");

    property p_sleep_cnv;
        state_r == PWR_SLEEP && strobe_rise && !sck_rise && supply_s
            |=> state_r == PWR_OPER ##1 settle_r == SETTLE_LOAD - CW'(1);
    endproperty
    a_sleep_cnv: assert property (p_sleep_cnv)
        else $error("fifth strobe did not wake");

    property p_por;
        !supply_s |=> state_r == PWR_OPER && !o_track ##1 o_settling;
    endproperty
    a_por: assert property (p_por)
        else $error("supply reset not applied");

    property p_cmos_low;
        !lvds_s && supply_s |=> !o_serial_out_ch1_n && !o_serial_out_ch2_n
            && !o_echo_clock_out_n_oe;
    endproperty
    a_cmos_low: assert property (p_cmos_low)
        else $error("negative pin driven in CMOS");

    property p_lvds_pair;
        lvds_s && supply_s |=> o_serial_out_ch1_n == !o_serial_out_ch1_p
            && o_echo_clock_out_n == !o_echo_clock_out_p;
    endproperty
    a_lvds_pair: assert property (p_lvds_pair)
        else $error("LVDS pair not complementary");

    property p_echo_off;
        !lvds_s && echo_strap_s && supply_s |=> !o_echo_clock_out_p;
    endproperty
    a_echo_off: assert property (p_echo_off)
        else $error("echo clock not disabled");

endmodule

// ==== tb/ctrl_model.sv ====
// Controller model: drives strobe and serial clock, captures all four lanes.
// Assumes the bench calls its tasks; serial clock period is 8 sys cycles.
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_lvds,
    input  wire logic [3:0]  i_sd,
    input  wire logic        i_echo,
    output logic             o_strobe,
    output logic             o_sck_p,
    output logic             o_sck_n,
    output logic [63:0]      o_word,
    output logic [5:0]       o_echo_cnt,
    output logic             o_done
);
    logic busy;
    logic echo_q;

    // Negative clock pin pulled low when single-ended
    assign o_sck_n = i_lvds ? ~o_sck_p : 1'b0;

    initial begin
        o_strobe = 1'b0;
        o_sck_p  = 1'b1;
        o_word   = '0;
        o_done   = 1'b0;
        busy     = 1'b0;
    end

    // Echo rises seen during one burst
    always @(posedge i_sys_clk) begin
        echo_q <= i_echo;
        if (!busy)
            o_echo_cnt <= '0;
        else if (i_echo && !echo_q)
            o_echo_cnt <= o_echo_cnt + 6'h01;
    end

    // Serial clock stays static high meanwhile
    task automatic strobe_pulse();
        @(posedge i_sys_clk);
        o_strobe <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        o_strobe <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
    endtask

    task automatic sck_tick();
        @(posedge i_sys_clk);
        o_sck_p <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        o_sck_p <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
    endtask

    // Sample late in each period, just before the next fall
    task automatic burst();
        busy = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge i_sys_clk);
            o_sck_p <= 1'b0;
            repeat (4) @(posedge i_sys_clk);
            o_sck_p <= 1'b1;
            repeat (3) @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            for (int j = 0; j < 4; j++)
                o_word[16 * j + i] = i_sd[j];
        end
        repeat (4) @(posedge i_sys_clk);
        o_done <= 1'b1;
        @(posedge i_sys_clk);
        o_done <= 1'b0;
        busy = 1'b0;
    endtask
endmodule

// ==== tb/tb_dual_sar_adc_serial_readout.sv ====
// Self-checking bench for the dual converter readout block.
// Assumes ctrl_model plays the controller; settle cut to 20 cycles.
`timescale 1ns/1ps
module tb_dual_sar_adc_serial_readout;
    import adc_readout_pkg::*;

    logic        i_sys_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_lvds_sel = 1'b0;
    logic        i_echo_clock_out_n = 1'b0;
    logic        i_supply_ok = 1'b1;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] i_ch1_result = 16'h0000;
    logic [15:0] i_ch2_result = 16'h0000;
    logic [15:0] o_rdata;
    logic [1:0]  o_power_state;
    logic        o_settling, echo_p, echo_oe, strobe, sck_p, sck_n, done;
    logic [3:0]  sd;
    logic [63:0] word;
    logic [5:0]  echo_cnt;
    logic        track;
    logic        conv_start;
    int          n_conv = 0;
    logic [69:0] notes[$];
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          seed = 54893;
    pwr_state_t  st_seq[5] = '{PWR_OPER, PWR_NAP, PWR_NAP, PWR_SLEEP,
                               PWR_OPER};

    always #12.5 i_sys_clk = ~i_sys_clk;

    dual_sar_adc_serial_readout #(.SETTLE_CYCLES(20)) i_dut (
        .i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_conversion_strobe(strobe), .i_sck_p(sck_p), .i_sck_n(sck_n),
        .i_lvds_sel(i_lvds_sel), .i_echo_clock_out_n(i_echo_clock_out_n),
        .i_supply_ok(i_supply_ok), .i_ch1_result(i_ch1_result),
        .i_ch2_result(i_ch2_result), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_track(track),
        .o_conv_start(conv_start), .o_serial_out_ch1_p(sd[0]),
        .o_serial_out_ch2_p(sd[1]), .o_serial_out_ch1_n(sd[2]),
        .o_serial_out_ch2_n(sd[3]), .o_echo_clock_out_p(echo_p),
        .o_echo_clock_out_n(), .o_echo_clock_out_n_oe(echo_oe),
        .o_power_state(o_power_state), .o_settling(o_settling));

    ctrl_model i_ctrl (
        .i_sys_clk(i_sys_clk), .i_lvds(i_lvds_sel), .i_sd(sd),
        .i_echo(echo_p), .o_strobe(strobe), .o_sck_p(sck_p),
        .o_sck_n(sck_n), .o_word(word), .o_echo_cnt(echo_cnt),
        .o_done(done));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp(input string msg, input logic [69:0] got,
                       input logic [69:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask

    // Oldest note pairs with each finished burst
    always @(posedge i_sys_clk) begin
        if (done === 1'b1)
            cmp("burst", {word, echo_cnt}, notes.pop_front());
    end

    // Conversion start pulses seen so far
    always @(posedge i_sys_clk) begin
        if (conv_start === 1'b1)
            n_conv++;
    end

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("mismatch t=%0t timeout", $time);
            wrap_up();
        end
    end

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        cmp("rdata", o_rdata, exp);
    endtask

    task automatic wait_settle();
        int k;
        k = 0;
        while (o_settling !== 1'b0 && k < 200) begin
            @(posedge i_sys_clk);
            k++;
        end
        cmp("settle", o_settling, 1'b0);
    endtask

    task automatic pulses(input int n);
        repeat (n) i_ctrl.strobe_pulse();
    endtask

    task automatic expect_burst(input logic [15:0] p1,
                                input logic [15:0] p2);
        logic [15:0] n1;
        logic [15:0] n2;
        logic [5:0]  e;
        int          c0;
        c0 = n_conv;
        // Pulse first so straps driven just before have settled
        i_ctrl.strobe_pulse();
        n1 = i_lvds_sel ? ~p1 : 16'h0000;
        n2 = i_lvds_sel ? ~p2 : 16'h0000;
        e = (i_lvds_sel || !i_echo_clock_out_n) ? 6'h10 : 6'h00;
        notes.push_back({n2, n1, p2, p1, e});
        cmp("conv", n_conv, c0 + 1);
        cmp("track", track, 1'b0);
        i_ctrl.burst();
    endtask

    task automatic convert_rand();
        logic [15:0] a;
        logic [15:0] b;
        a = 16'($random(seed));
        b = 16'($random(seed));
        i_ch1_result <= a;
        i_ch2_result <= b;
        expect_burst(a, b);
    endtask

    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        wait_settle();
        reg_rd(CTRL_OFS, CTRL_RST);
        reg_rd(PATTERN_OFS, PATTERN_RST);
        reg_rd(4'hc, 16'h0000);
        reg_rd(STATUS_OFS, 16'h0014);
        cmp("oe", echo_oe, 1'b0);
        repeat (3) convert_rand();
        reg_wr(PATTERN_OFS, 16'ha5c3);
        reg_wr(CTRL_OFS, 16'h0001);
        expect_burst(16'ha5c3, 16'h5a3c);
        reg_wr(CTRL_OFS, 16'h0000);
        reg_wr(STATUS_OFS, 16'hffff);
        reg_rd(STATUS_OFS, 16'h0014);
        i_echo_clock_out_n <= 1'b1;
        convert_rand();
        i_echo_clock_out_n <= 1'b0;
        for (int p = 0; p < 10; p++) begin
            i_ctrl.strobe_pulse();
            cmp("state", o_power_state, st_seq[p % 5]);
        end
        wait_settle();
        pulses(2);
        cmp("state", o_power_state, PWR_NAP);
        i_ctrl.sck_tick();
        cmp("state", o_power_state, PWR_OPER);
        i_ctrl.sck_tick();
        pulses(4);
        cmp("state", o_power_state, PWR_SLEEP);
        i_ctrl.sck_tick();
        cmp("state", o_power_state, PWR_OPER);
        cmp("settling", o_settling, 1'b1);
        wait_settle();
        pulses(2);
        i_supply_ok <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        cmp("state", o_power_state, PWR_OPER);
        cmp("settling", o_settling, 1'b1);
        i_supply_ok <= 1'b1;
        wait_settle();
        i_lvds_sel <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        cmp("oe", echo_oe, 1'b1);
        convert_rand();
        pulses(4);
        i_ctrl.sck_tick();
        cmp("state", o_power_state, PWR_SLEEP);
        pulses(1);
        cmp("state", o_power_state, PWR_OPER);
        wait_settle();
        convert_rand();
        repeat (10) @(posedge i_sys_clk);
        wrap_up();
    end
endmodule
